// >>> pkg/hcb_pkg.sv
// Constants and types shared by the host CPU bus port
package hcb_pkg;
  localparam int CLK_NS = 10;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  // Strobe recovery, ordinary and for host operational registers
  localparam int GAP_NS = 25;
  localparam int GAP_EHCI_NS = 195;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_EHCI_CYC = (GAP_EHCI_NS + CLK_NS - 1) / CLK_NS;
  // Memory read strobe cycle time, low and 3.3 V I/O supply
  localparam int MEM_CY_LV_NS = 40;
  localparam int MEM_CY_HV_NS = 36;
  localparam int MEM_CY_LV_CYC = (MEM_CY_LV_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEM_CY_HV_CYC = (MEM_CY_HV_NS + CLK_NS - 1) / CLK_NS;
  // Longest times the device must meet
  localparam int RD_VALID_LV_NS = 35;
  localparam int RD_VALID_HV_NS = 22;
  localparam int RD_VALID_CYC = RD_VALID_HV_NS / CLK_NS;
  localparam int REQ_DROP_LV_NS = 29;
  localparam int REQ_DROP_HV_NS = 18;
  localparam int REQ_DROP_CYC = REQ_DROP_HV_NS / CLK_NS;
  localparam int REQ_AGAIN_NS = 56;
  localparam int REQ_AGAIN_CYC = REQ_AGAIN_NS / CLK_NS;
  // Address map of the decode used by the recovery checker
  localparam logic [ADDR_W-1:0] EHCI_OP_LO = 18'h00020;
  localparam logic [ADDR_W-1:0] EHCI_OP_HI = 18'h00044;
  localparam logic [ADDR_W-1:0] MEM_BASE = 18'h00400;
  localparam logic [4:0] GAP_CNT_MAX = 5'h1F;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  typedef enum logic [1:0] {
    HCB_DMA_IDLE,
    HCB_DMA_REQ,
    HCB_DMA_BUSY
  } hcb_dma_state_t;
endpackage

// >>> pkg/hcb_fifo_if.sv
// Push and pop handshakes between the port and its DMA FIFO
`timescale 1ns/1ns
`default_nettype none
interface hcb_fifo_if;
  import hcb_pkg::*;
  logic in_valid;
  logic in_ready;
  logic [DATA_W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [DATA_W-1:0] out_data;
  modport fifo (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface
`default_nettype wire

// >>> hw/hcb_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module hcb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  hcb_fifo_if.fifo bus
);
  import hcb_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;
  logic in_ready;
  logic out_valid;

  assign push = bus.in_valid && in_ready;
  assign pop = bus.out_ready && out_valid;
  assign bus.in_ready = in_ready;
  assign bus.out_valid = out_valid;
  assign bus.out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  // Flags are registered from the next count so both stay honest
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= bus.in_data;
    end
  end
endmodule
`default_nettype wire

// >>> hw/hcb_cpu_port.sv
// Device end of the asynchronous CPU bus with single-cycle DMA reads
// Summary of operation
// RULE1 - DMA request and acknowledge are both active high.
// RULE2 - Master leaves 25 ns between any strobe rise and next fall.
// RULE3 - Host operational register gaps stretch to 195 ns.
// RULE4 - Memory read strobes spaced 40 ns low supply, 36 ns at 3.3 V.
// RULE5 - Register read data valid within 35 or 22 ns of read fall.
// RULE6 - Write strobe low 17 ns; address, data, select set up 5 ns.
// RULE7 - Acknowledge rises only at or after the DMA request.
// RULE8 - DMA read strobe falls only at or after acknowledge.
// RULE9 - DMA request drops within 29 or 18 ns of DMA read fall.
// RULE10 - Request returns within 56 ns of acknowledge release if data waits.
// RULE11 - Writes captured at write rise with select active; else ignored.
`timescale 1ns/1ns
`default_nettype none
module hcb_cpu_port (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [hcb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [hcb_pkg::DATA_W-1:0] i_data,
  output logic [hcb_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_dma_request_line,
  input wire logic i_dma_acknowledge_line,
  input wire logic i_low_vio,
  output logic o_wr_valid,
  output logic [hcb_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [hcb_pkg::DATA_W-1:0] o_wr_data,
  output logic o_rd_strobe,
  output logic [hcb_pkg::ADDR_W-1:0] o_rd_addr,
  input wire logic [hcb_pkg::DATA_W-1:0] i_rd_data,
  input wire logic i_dma_valid,
  input wire logic [hcb_pkg::DATA_W-1:0] i_dma_data,
  output logic o_dma_ready,
  output logic o_gap_violation
);
  import hcb_pkg::*;

  hcb_fifo_if fbus ();

  hcb_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) i_hcb_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .bus(fbus)
  );

  hcb_dma_state_t state;
  hcb_dma_state_t next_state;
  logic rd_q;
  logic wr_q;
  logic rd_fall;
  logic wr_fall;
  logic rd_rise;
  logic wr_rise;
  logic dma_rd;
  logic pio_rd;
  logic wr_armed;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic [4:0] gap_cnt;
  logic [4:0] rd_cy_cnt;
  logic last_ehci;
  logic last_mem_rd;
  logic last_rd;
  logic cur_ehci;
  logic cur_mem;
  logic [4:0] gap_need;
  logic [4:0] mem_need;

  // Inputs are synchronous, so one stage of history finds the edges
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_q <= 1'b1;
      wr_q <= 1'b1;
    end else begin
      rd_q <= i_rd_n;
      wr_q <= i_wr_n;
    end
  end

  assign rd_fall = rd_q && !i_rd_n;
  assign wr_fall = wr_q && !i_wr_n;
  assign rd_rise = !rd_q && i_rd_n;
  assign wr_rise = !wr_q && i_wr_n;
  assign dma_rd = rd_fall && i_dma_acknowledge_line; // RULE1 RULE8
  assign pio_rd = rd_fall && !i_cs_n && !i_dma_acknowledge_line;

  // DMA request sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      HCB_DMA_IDLE: begin
        // Data waiting and acknowledge released: ask again at once
        if (fbus.out_valid && !i_dma_acknowledge_line) begin
          next_state = HCB_DMA_REQ; // RULE10
        end
      end
      HCB_DMA_REQ: begin
        if (dma_rd) begin
          next_state = HCB_DMA_BUSY; // RULE9
        end
      end
      HCB_DMA_BUSY: begin
        if (!i_dma_acknowledge_line && i_rd_n) begin
          next_state = HCB_DMA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= HCB_DMA_IDLE;
      o_dma_request_line <= 1'b0;
    end else begin
      state <= next_state;
      // Drops one clock after the sampled read fall
      o_dma_request_line <= next_state == HCB_DMA_REQ; // RULE1 RULE9
    end
  end

  // A word is popped only for a read taken while the request stands,
  // which relies on the controller keeping acknowledge after request
  assign fbus.out_ready = dma_rd && state == HCB_DMA_REQ; // RULE7
  assign fbus.in_valid = i_dma_valid;
  assign fbus.in_data = i_dma_data;
  assign o_dma_ready = fbus.in_ready;

  // Read data: driven one clock after the sampled fall, inside 22 ns
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data <= DATA_RST;
      o_data_oe <= 1'b0;
      o_rd_strobe <= 1'b0;
      o_rd_addr <= '0;
    end else begin
      o_rd_strobe <= pio_rd;
      if (pio_rd) begin
        o_data <= i_rd_data; // RULE5
        o_rd_addr <= i_addr;
      end else if (fbus.out_ready) begin
        o_data <= fbus.out_data;
      end
      o_data_oe <= !i_rd_n && (!i_cs_n || i_dma_acknowledge_line); // RULE5
    end
  end

  // Write capture: the last sample taken while the strobe is low is
  // the one that sits inside the 5 ns set-up before the rise
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_armed <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= DATA_RST;
    end else begin
      if (!i_wr_n && !i_cs_n) begin
        wr_armed <= 1'b1; // RULE11
        wr_addr_q <= i_addr;
        wr_data_q <= i_data;
      end else if (i_wr_n) begin
        wr_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wr_valid <= 1'b0;
      o_wr_addr <= '0;
      o_wr_data <= DATA_RST;
    end else begin
      o_wr_valid <= wr_rise && wr_armed; // RULE6 RULE11
      if (wr_rise && wr_armed) begin
        o_wr_addr <= wr_addr_q;
        o_wr_data <= wr_data_q;
      end
    end
  end

  // Recovery checker: flags a master that breaks the strobe gaps
  assign cur_ehci = i_addr >= EHCI_OP_LO && i_addr <= EHCI_OP_HI;
  assign cur_mem = i_addr >= MEM_BASE;
  // Read followed by write keeps the short gap even for these registers
  assign gap_need = (last_ehci && !(last_rd && wr_fall))
    ? 5'(GAP_EHCI_CYC) : 5'(GAP_CYC);
  assign mem_need = i_low_vio ? 5'(MEM_CY_LV_CYC) : 5'(MEM_CY_HV_CYC);

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_cnt <= GAP_CNT_MAX;
      rd_cy_cnt <= GAP_CNT_MAX;
      last_ehci <= 1'b0;
      last_mem_rd <= 1'b0;
      last_rd <= 1'b0;
      o_gap_violation <= 1'b0;
    end else begin
      if (rd_rise || wr_rise) begin
        gap_cnt <= 5'h01;
      end else if (gap_cnt != GAP_CNT_MAX) begin
        gap_cnt <= gap_cnt + 5'h01;
      end
      if (rd_fall) begin
        rd_cy_cnt <= 5'h01;
      end else if (rd_cy_cnt != GAP_CNT_MAX) begin
        rd_cy_cnt <= rd_cy_cnt + 5'h01;
      end
      if ((rd_fall || wr_fall) && !i_cs_n) begin
        last_ehci <= cur_ehci;
        last_mem_rd <= rd_fall && cur_mem;
        last_rd <= rd_fall;
      end
      o_gap_violation <= ((rd_fall || wr_fall) && !i_cs_n
          && gap_cnt < gap_need) // RULE2 RULE3
        || (rd_fall && !i_cs_n && cur_mem && last_mem_rd
          && rd_cy_cnt < mem_need); // RULE4
    end
  end
endmodule
`default_nettype wire

// >>> testbench/hcb_cpu_port_monitor.sv
// Concurrent checks on the host CPU bus port
`timescale 1ns/1ns
`default_nettype none
module hcb_cpu_port_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [hcb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [hcb_pkg::DATA_W-1:0] i_rd_data,
  input wire logic [hcb_pkg::DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_dma_request_line,
  input wire logic i_dma_acknowledge_line,
  input wire logic o_wr_valid,
  input wire logic [hcb_pkg::ADDR_W-1:0] o_wr_addr,
  input wire logic i_dma_valid,
  input wire logic o_dma_ready,
  input wire logic o_gap_violation
);
  import hcb_pkg::*;
  logic [2:0] hi_cnt;
  logic [2:0] cnt;
  logic s_q;
  logic req_q;
  wire logic s = !(i_rd_n && i_wr_n);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // Saturated at reset so the first strobe never looks too early
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      hi_cnt <= 3'h7;
      s_q <= 1'b0;
      req_q <= 1'b0;
      cnt <= 3'h0;
    end else begin
      s_q <= s;
      req_q <= o_dma_request_line;
      hi_cnt <= s ? 3'h0 : (hi_cnt == 3'h7 ? hi_cnt : hi_cnt + 3'h1);
      cnt <= cnt + 3'(i_dma_valid & o_dma_ready)
        - 3'(req_q & !o_dma_request_line);
    end
  end
  a_req_drop: assert property (
    $fell(i_rd_n) && i_dma_acknowledge_line && o_dma_request_line
    |=> !o_dma_request_line && o_data_oe) else $error("request not dropped");
  a_rd_data: assert property (
    $fell(i_rd_n) && !i_cs_n && !i_dma_acknowledge_line
    |=> o_data_oe && o_data == $past(i_rd_data)) else $error("read data late");
  a_wr_capture: assert property (
    $rose(i_wr_n) && !$past(i_cs_n) |=> o_wr_valid
    && o_wr_addr == $past(i_addr, 2)) else $error("write not captured");
  a_wr_cause: assert property (
    o_wr_valid |-> $past(i_wr_n) && !$past(i_wr_n, 2))
    else $error("write pulse without strobe");
  a_wr_single: assert property (
    o_wr_valid |=> !o_wr_valid) else $error("write pulse too long");
  a_oe_release: assert property (
    $rose(i_rd_n) |=> !o_data_oe) else $error("bus still driven");
  a_gap_flag: assert property (
    s && !s_q && !i_cs_n && hi_cnt < 3'h3 |=> o_gap_violation)
    else $error("short gap not flagged");
  a_req_return: assert property (
    $fell(i_dma_acknowledge_line) && cnt != 3'h0
    |-> ##[1:5] o_dma_request_line) else $error("request not renewed");
endmodule
bind hcb_cpu_port hcb_cpu_port_monitor i_hcb_cpu_port_monitor (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .i_wr_n(i_wr_n), .i_addr(i_addr), .i_rd_data(i_rd_data), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_dma_request_line(o_dma_request_line),
  .i_dma_acknowledge_line(i_dma_acknowledge_line), .o_wr_valid(o_wr_valid),
  .o_wr_addr(o_wr_addr), .i_dma_valid(i_dma_valid),
  .o_dma_ready(o_dma_ready), .o_gap_violation(o_gap_violation));
`default_nettype wire

// >>> testbench/hcb_host_model.sv
// External CPU and DMA controller driving the host bus
`timescale 1ns/1ns
`default_nettype none
module hcb_host_model (
  input wire logic i_clk_sys,
  input wire logic i_req,
  input wire logic [hcb_pkg::DATA_W-1:0] i_bus,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_ack,
  output logic [hcb_pkg::ADDR_W-1:0] o_addr,
  output logic [hcb_pkg::DATA_W-1:0] o_data
);
  import hcb_pkg::*;
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_ack} = 4'hE;
    o_addr = '0;
    o_data = '0;
  end
  // Released lines flip so a stale value is never mistaken for a good one
  task automatic release_bus();
    @(negedge i_clk_sys);
    o_cs_n = 1'b1;
    o_addr = ~o_addr;
    o_data = ~o_data;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic cs, input int g);
    repeat (g + 1) @(negedge i_clk_sys);
    o_cs_n = cs;
    o_addr = a;
    o_data = d;
    o_wr_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    o_wr_n = 1'b1;
    release_bus();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input int g,
                    output logic [DATA_W-1:0] q);
    repeat (g + 1) @(negedge i_clk_sys);
    o_cs_n = 1'b0;
    o_addr = a;
    o_rd_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    q = i_bus;
    o_rd_n = 1'b1;
    release_bus();
  endtask
  task automatic dma_rd(input int w, output logic [DATA_W-1:0] q,
                        output logic ok);
    ok = 1'b0;
    repeat (w) @(negedge i_clk_sys);
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge i_clk_sys);
      ok = i_req;
    end
    if (ok) begin
      o_ack = 1'b1;
      @(negedge i_clk_sys);
      o_rd_n = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      q = i_bus;
      o_rd_n = 1'b1;
      o_ack = 1'b0;
      @(negedge i_clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_host_cpu_bus_pio_dma_timing.sv
// Self-checking bench for the host CPU bus port
`timescale 1ns/1ns
`default_nettype none
module test_host_cpu_bus_pio_dma_timing;
  import hcb_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic low_vio = 1'b1;
  logic dma_valid = 1'b0;
  logic [DATA_W-1:0] dma_data = '0;
  logic cs_n, rd_n, wr_n, ack, oe, req, wr_v, ready, gap, rd_stb;
  logic [ADDR_W-1:0] addr, wr_addr, rd_addr;
  logic [DATA_W-1:0] wdata, bus, wr_data;
  wire logic [DATA_W-1:0] rd_data = {14'h2AAA, addr};
  int err_count = 0;
  int checks_done = 0;
  int wr_seen = 0;
  int gap_seen = 0;
  int rd_seen = 0;
  hcb_cpu_port i_hcb_cpu_port (.i_clk_sys(clk), .i_rstn(rstn), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(bus),
    .o_data_oe(oe), .o_dma_request_line(req), .i_dma_acknowledge_line(ack),
    .i_low_vio(low_vio), .o_wr_valid(wr_v), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_rd_strobe(rd_stb), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_dma_valid(dma_valid), .i_dma_data(dma_data), .o_dma_ready(ready),
    .o_gap_violation(gap));
  hcb_host_model i_hcb_host_model (.i_clk_sys(clk), .i_req(req), .i_bus(bus),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ack(ack), .o_addr(addr),
    .o_data(wdata));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_v === 1'b1) wr_seen++;
    if (gap === 1'b1) gap_seen++;
    if (rd_stb === 1'b1) rd_seen++;
  end
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_write();
    int n;
    n = wr_seen;
    i_hcb_host_model.wr(18'h00100, 32'hCAFE0001, 1'b0, GAP_CYC);
    repeat (2) @(negedge clk);
    cmp("write pulses", n + 1, wr_seen);
    cmp("write addr", 32'(18'h00100), 32'(wr_addr));
    cmp("write data", 32'hCAFE0001, wr_data);
    i_hcb_host_model.wr(18'h00104, 32'h12345678, 1'b1, GAP_CYC);
    repeat (2) @(negedge clk);
    cmp("deselected write", n + 1, wr_seen);
    cmp("data kept", 32'hCAFE0001, wr_data);
  endtask
  task automatic t_read();
    logic [31:0] q;
    int n;
    n = rd_seen;
    i_hcb_host_model.rd(18'h00200, GAP_CYC, q);
    cmp("pio read", {14'h2AAA, 18'h00200}, q);
    cmp("bus released", 32'h0, 32'(oe));
    cmp("read strobes", n + 1, rd_seen);
    cmp("read addr", 32'(18'h00200), 32'(rd_addr));
  endtask
  // Only a write after a read keeps the short gap at operational registers
  task automatic t_gap();
    logic [31:0] q;
    int n;
    n = gap_seen;
    low_vio = 1'b0;
    i_hcb_host_model.rd(18'h00200, 0, q);
    cmp("short gap", n + 1, gap_seen);
    i_hcb_host_model.wr(18'h00020, 32'h1, 1'b0, GAP_CYC);
    i_hcb_host_model.wr(18'h00024, 32'h2, 1'b0, GAP_CYC);
    cmp("op reg gap", n + 2, gap_seen);
    i_hcb_host_model.rd(18'h00024, GAP_EHCI_CYC, q);
    cmp("long op gap", n + 2, gap_seen);
    cmp("op reg read", {14'h2AAA, 18'h00024}, q);
    i_hcb_host_model.wr(18'h00020, 32'h3, 1'b0, GAP_CYC);
    cmp("write after op read", n + 2, gap_seen);
  endtask
  task automatic t_dma();
    logic [31:0] q;
    logic ok;
    int n;
    n = 0;
    while (n < 8) begin
      @(negedge clk);
      if (ready !== 1'b1) break;
      dma_data = 32'hD0000000 + 32'(n);
      dma_valid = 1'b1;
      n++;
    end
    dma_valid = 1'b0;
    cmp("fifo words", FIFO_DEPTH, n);
    for (int i = 0; i < 5; i++) begin
      i_hcb_host_model.dma_rd(i * 3, q, ok);
      cmp("request seen", 32'(i < FIFO_DEPTH), 32'(ok));
      if (ok === 1'b1) cmp("dma word", 32'hD0000000 + 32'(i), q);
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    t_write();
    t_read();
    t_gap();
    t_dma();
    final_report();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
